// ===== common/far_pkg.sv
// Constants and types for the fault auto restart sequencer.
// Assumes one 250 MHz system clock and second-based timers.
package far_pkg;

    // Clock rate and the one-second tick derived from it
    localparam int unsigned CLK_HZ    = 250_000_000;
    localparam int unsigned TICK_S    = 1;
    localparam int unsigned TICK_CYC  = CLK_HZ * TICK_S;
    localparam int          TICK_W    = 28;

    // Field widths
    localparam int          SEC_W     = 13;
    localparam int          CNT_W     = 4;
    localparam int          OUT_W     = 24;
    localparam int          PROD_W    = SEC_W + CNT_W;
    localparam int          TRIP_W    = 8;
    localparam int          PIN_W     = 3;

    // Pin vector positions
    localparam int          PIN_START = 0;
    localparam int          PIN_STOP  = 1;
    localparam int          PIN_RST   = 2;

    // Programmable limits
    localparam logic [SEC_W-1:0] DELAY_MAX = 13'h1C20;
    localparam logic [CNT_W-1:0] ATT_MAX   = 4'hA;
    localparam logic [SEC_W-1:0] FREE_MIN  = 13'h0078;
    localparam logic [SEC_W-1:0] FREE_MAX  = 13'h1C20;
    localparam logic [SEC_W-1:0] SEC_ZERO  = 13'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;

    // Start/stop command source
    localparam logic [1:0] MODE_2W   = 2'h0;
    localparam logic [1:0] MODE_3W   = 2'h1;
    localparam logic [1:0] MODE_COMM = 2'h2;

    // Saved sequence phase
    localparam logic PH_DELAY = 1'b0;
    localparam logic PH_RUN   = 1'b1;

    // Sequencer states, Gray along power-up, idle, wait, restart, run
    typedef enum logic [2:0] {
        ST_PWRUP   = 3'h0,
        ST_IDLE    = 3'h1,
        ST_DELAY   = 3'h3,
        ST_RESTART = 3'h2,
        ST_RUN     = 3'h6,
        ST_LOCKOUT = 3'h7
    } far_state_t;

endpackage : far_pkg

// ===== core/far_sequencer.sv
// Fault auto restart sequencer: retries a start after selected trips.
// Assumes trips and comms commands come from the same clock;
// start, stop and reset pins are asynchronous. A retained store outside
// holds the nv_* outputs across a control supply loss and returns them
// with the outage length on restore_i.
`timescale 1ns/1ps
`default_nettype none

module far_sequencer #(
    parameter int unsigned TICK_CYCLES = far_pkg::TICK_CYC  // Shorten in simulation
) (
    input  wire logic                       ref_clk_i,      // System clock
    input  wire logic                       rst_n_i,        // Sync reset, low
    input  wire logic                       clk_en_i,       // Freezes state when low
    input  wire logic                       ar_enable_i,    // Auto restart on
    input  wire logic [far_pkg::SEC_W-1:0]  delay_s_i,      // Retry wait, s
    input  wire logic [far_pkg::CNT_W-1:0]  attempts_i,     // Retry limit
    input  wire logic [far_pkg::SEC_W-1:0]  free_s_i,       // Trip-free time, s
    input  wire logic [far_pkg::TRIP_W-1:0] trip_sel_i,     // Resettable set
    input  wire logic [far_pkg::TRIP_W-1:0] trip_i,         // Active trips
    input  wire logic [1:0]                 mode_i,         // Command source
    input  wire logic                       hand_opt_i,     // Hand/auto option
    input  wire logic                       hand_sel_i,     // Hand selected
    input  wire logic [far_pkg::PIN_W-1:0]  pins_i,         // Reset, stop, start
    input  wire logic                       comm_start_i,   // Comms start pulse
    input  wire logic                       comm_stop_i,    // Comms stop pulse
    input  wire logic                       restore_i,      // Power-up restore pulse
    input  wire logic [far_pkg::OUT_W-1:0]  outage_s_i,     // Unpowered time, s
    input  wire logic                       rs_active_i,    // Saved: sequence on
    input  wire logic                       rs_phase_i,     // Saved: phase
    input  wire logic                       rs_start_i,     // Saved: start state
    input  wire logic [far_pkg::CNT_W-1:0]  rs_att_i,       // Saved attempts left
    input  wire logic [far_pkg::SEC_W-1:0]  rs_delay_i,     // Saved wait left
    input  wire logic [far_pkg::SEC_W-1:0]  rs_free_i,      // Saved free left
    output logic                            trip_clear_o,   // Clear trip pulse
    output logic                            start_req_o,    // Restart pulse
    output logic                            trip_reset_o,   // Two-wire reset pulse
    output logic                            rst_inhibit_o,  // Mask remote-start trip
    output logic [far_pkg::CNT_W-1:0]       att_left_o,     // Attempts left
    output logic [far_pkg::SEC_W-1:0]       delay_left_o,   // Wait left, s
    output logic                            pending_o,      // Restart pending
    output logic [far_pkg::SEC_W-1:0]       free_left_o,    // Trip-free left, s
    output logic                            lockout_o,      // Retries exhausted
    output logic                            nv_active_o,    // Save: sequence on
    output logic                            nv_phase_o,     // Save: phase
    output logic                            nv_start_o      // Save: start state
);

    // Saturating limit helper, used for wait and trip-free time settings
    function automatic logic [far_pkg::SEC_W-1:0] sat_max(
        input logic [far_pkg::SEC_W-1:0] v,
        input logic [far_pkg::SEC_W-1:0] m
    );
        sat_max = (v > m) ? m : v;
    endfunction : sat_max

    // Saturating subtract of outage time from a saved countdown
    function automatic logic [far_pkg::SEC_W-1:0] sub_sat(
        input logic [far_pkg::SEC_W-1:0] v,
        input logic [far_pkg::OUT_W-1:0] d
    );
        sub_sat = ({11'h000, v} > d) ? (v - d[far_pkg::SEC_W-1:0]) : far_pkg::SEC_ZERO;
    endfunction : sub_sat

    localparam logic [far_pkg::TICK_W-1:0] TICK_LAST = far_pkg::TICK_W'(TICK_CYCLES - 1);

    logic [far_pkg::PIN_W-1:0]  meta_reg;
    logic [far_pkg::PIN_W-1:0]  sync_reg;
    logic [far_pkg::PIN_W-1:0]  prev_reg;
    logic [far_pkg::TICK_W-1:0] tick_cnt_reg;
    logic                       tick;
    logic                       run_cmd_reg;
    far_pkg::far_state_t        state_reg, state_next;
    logic [far_pkg::CNT_W-1:0]  att_reg, att_next;
    logic [far_pkg::SEC_W-1:0]  dly_reg, dly_next;
    logic [far_pkg::SEC_W-1:0]  free_reg, free_next;
    logic                       pulse_next;
    logic [far_pkg::SEC_W-1:0]  delay_set;
    logic [far_pkg::CNT_W-1:0]  att_set;
    logic [far_pkg::SEC_W-1:0]  free_set;
    logic [far_pkg::PROD_W-1:0] budget;
    logic                       two_wire;
    logic                       fault;
    logic                       start_rise;
    logic                       stop_evt;
    logic                       op_reset;
    logic                       hand;
    logic                       abort;

    // Two-flop synchronisers for the asynchronous pins
    genvar gi;
    generate
        for (gi = 0; gi < far_pkg::PIN_W; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                    prev_reg[gi] <= 1'b0;
                end else if (clk_en_i) begin
                    meta_reg[gi] <= pins_i[gi];
                    sync_reg[gi] <= meta_reg[gi];
                    prev_reg[gi] <= sync_reg[gi];
                end
            end
        end
    endgenerate

    // Settings clamped to their legal ranges
    assign delay_set = sat_max(delay_s_i, far_pkg::DELAY_MAX);
    assign att_set   = (attempts_i > far_pkg::ATT_MAX) ? far_pkg::ATT_MAX : attempts_i;
    assign free_set  = (free_s_i < far_pkg::FREE_MIN) ? far_pkg::FREE_MIN
                                                      : sat_max(free_s_i, far_pkg::FREE_MAX);
    assign budget    = far_pkg::PROD_W'(delay_set * att_set);

    // Command decode; two-wire takes stop from the start level low and a reset from its rise
    assign two_wire   = (mode_i == far_pkg::MODE_2W);
    assign fault      = |(trip_i & trip_sel_i);
    assign start_rise = sync_reg[far_pkg::PIN_START] & ~prev_reg[far_pkg::PIN_START];
    assign stop_evt   = two_wire ? ~sync_reg[far_pkg::PIN_START]
                                 : (comm_stop_i
                                    | (sync_reg[far_pkg::PIN_STOP] & ~prev_reg[far_pkg::PIN_STOP]));
    assign op_reset   = (sync_reg[far_pkg::PIN_RST] & ~prev_reg[far_pkg::PIN_RST])
                        | (two_wire & start_rise);
    assign hand       = hand_opt_i & hand_sel_i;
    assign abort      = hand | op_reset | stop_evt | ~ar_enable_i;

    // Second tick; held in reset until the power-up restore is done
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || state_reg == far_pkg::ST_PWRUP) begin
            tick_cnt_reg <= '0;
        end else if (clk_en_i) begin
            tick_cnt_reg <= (tick_cnt_reg >= TICK_LAST) ? '0 : tick_cnt_reg + 1'b1;
        end
    end
    assign tick = clk_en_i && (tick_cnt_reg >= TICK_LAST);

    // Latched start for three-wire and comms; saved across supply loss
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            run_cmd_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (state_reg == far_pkg::ST_PWRUP) begin
                if (restore_i) begin
                    run_cmd_reg <= rs_start_i;
                end
            end else if (two_wire) begin
                run_cmd_reg <= sync_reg[far_pkg::PIN_START];
            end else if (stop_evt) begin
                run_cmd_reg <= 1'b0;
            end else if (comm_start_i
                         || (sync_reg[far_pkg::PIN_START] && !prev_reg[far_pkg::PIN_START])) begin
                run_cmd_reg <= 1'b1;
            end
        end
    end

    // Sequencer next state and counters
    always_comb begin
        state_next = state_reg;
        att_next   = att_reg;
        dly_next   = dly_reg;
        free_next  = free_reg;
        pulse_next = 1'b0;
        case (state_reg)
            far_pkg::ST_PWRUP: begin
                if (restore_i) begin
                    state_next = far_pkg::ST_IDLE;
                    att_next   = att_set;
                    dly_next   = far_pkg::SEC_ZERO;
                    free_next  = far_pkg::SEC_ZERO;
                    if (rs_active_i && ar_enable_i && !hand
                        && (two_wire ? sync_reg[far_pkg::PIN_START] : rs_start_i)
                        && (outage_s_i <= far_pkg::OUT_W'(budget))) begin
                        att_next = rs_att_i;
                        if (rs_phase_i == far_pkg::PH_DELAY) begin
                            state_next = far_pkg::ST_DELAY;
                            dly_next   = sub_sat(rs_delay_i, outage_s_i);
                        end else if (sub_sat(rs_free_i, outage_s_i) != far_pkg::SEC_ZERO) begin
                            state_next = far_pkg::ST_RUN;
                            free_next  = sub_sat(rs_free_i, outage_s_i);
                        end else begin
                            att_next = att_set;
                        end
                    end
                end
            end
            far_pkg::ST_IDLE: begin
                att_next = att_set;
                if (ar_enable_i && fault && run_cmd_reg && !hand) begin
                    if (att_set == far_pkg::CNT_ZERO) begin
                        state_next = far_pkg::ST_LOCKOUT;
                    end else begin
                        state_next = far_pkg::ST_DELAY;
                        dly_next   = delay_set;
                    end
                end
            end
            far_pkg::ST_DELAY: begin
                if (abort) begin
                    state_next = far_pkg::ST_IDLE;
                    att_next   = att_set;
                    dly_next   = far_pkg::SEC_ZERO;
                end else if (dly_reg == far_pkg::SEC_ZERO) begin
                    state_next = far_pkg::ST_RESTART;
                end else if (tick) begin
                    dly_next = dly_reg - 1'b1;
                end
            end
            far_pkg::ST_RESTART: begin
                pulse_next = 1'b1;
                att_next   = att_reg - 1'b1;
                free_next  = free_set;
                state_next = far_pkg::ST_RUN;
            end
            far_pkg::ST_RUN: begin
                if (abort) begin
                    state_next = far_pkg::ST_IDLE;
                    att_next   = att_set;
                    free_next  = far_pkg::SEC_ZERO;
                end else if (fault) begin
                    free_next = far_pkg::SEC_ZERO;
                    if (att_reg == far_pkg::CNT_ZERO) begin
                        state_next = far_pkg::ST_LOCKOUT;
                    end else begin
                        state_next = far_pkg::ST_DELAY;
                        dly_next   = delay_set;
                    end
                end else if (free_reg == far_pkg::SEC_ZERO) begin
                    state_next = far_pkg::ST_IDLE;
                    att_next   = att_set;
                end else if (tick) begin
                    free_next = free_reg - 1'b1;
                end
            end
            far_pkg::ST_LOCKOUT: begin
                if (op_reset || stop_evt || hand || !ar_enable_i) begin
                    state_next = far_pkg::ST_IDLE;
                    att_next   = att_set;
                end
            end
            default: begin
                state_next = far_pkg::ST_IDLE;
            end
        endcase
    end

    // State register; power-up waits for the restore
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg <= far_pkg::ST_PWRUP;
        end else if (clk_en_i) begin
            state_reg <= state_next;
        end
    end

    // Countdowns and attempt counter
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            att_reg  <= far_pkg::CNT_ZERO;
            dly_reg  <= far_pkg::SEC_ZERO;
            free_reg <= far_pkg::SEC_ZERO;
        end else if (clk_en_i) begin
            att_reg  <= att_next;
            dly_reg  <= dly_next;
            free_reg <= free_next;
        end
    end

    // Restart pulses, one cycle each
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            trip_clear_o <= 1'b0;
            start_req_o  <= 1'b0;
            trip_reset_o <= 1'b0;
        end else if (clk_en_i) begin
            trip_clear_o <= pulse_next;
            start_req_o  <= pulse_next;
            trip_reset_o <= two_wire & start_rise;
        end
    end

    // Live status and retained values
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            att_left_o    <= far_pkg::CNT_ZERO;
            delay_left_o  <= far_pkg::SEC_ZERO;
            free_left_o   <= far_pkg::SEC_ZERO;
            pending_o     <= 1'b0;
            lockout_o     <= 1'b0;
            rst_inhibit_o <= 1'b0;
            nv_active_o   <= 1'b0;
            nv_phase_o    <= far_pkg::PH_DELAY;
            nv_start_o    <= 1'b0;
        end else if (clk_en_i) begin
            att_left_o    <= att_next;
            delay_left_o  <= dly_next;
            free_left_o   <= free_next;
            pending_o     <= (state_next == far_pkg::ST_DELAY)
                             || (state_next == far_pkg::ST_RESTART);
            lockout_o     <= (state_next == far_pkg::ST_LOCKOUT);
            rst_inhibit_o <= ar_enable_i;
            nv_active_o   <= (state_next == far_pkg::ST_DELAY)
                             || (state_next == far_pkg::ST_RESTART)
                             || (state_next == far_pkg::ST_RUN);
            nv_phase_o    <= (state_next == far_pkg::ST_RUN) ? far_pkg::PH_RUN : far_pkg::PH_DELAY;
            nv_start_o    <= run_cmd_reg;
        end
    end

endmodule : far_sequencer

`default_nettype wire

// ===== testbench/far_cmd_model.sv
// Command source model: start, stop and reset pins plus comms pulses.
// Assumes the bench calls cmd() from one process only.
`timescale 1ns/1ps
`default_nettype none
module far_cmd_model (
    input  wire logic                      ref_clk_i,    // System clock
    input  wire logic [1:0]                mode_i,       // Command source
    output logic      [far_pkg::PIN_W-1:0] pins_o,       // Start, stop, reset
    output logic                           comm_start_o, // Comms start
    output logic                           comm_stop_o   // Comms stop
);
    // Idle levels from time zero
    initial begin
        pins_o       = '0;
        comm_start_o = 1'b0;
        comm_stop_o  = 1'b0;
    end
    // Kind 0 start, 1 stop, 2 reset, 3 remove the start level
    task automatic cmd(input int k);
        @(negedge ref_clk_i);
        if (k == 3) begin
            pins_o[far_pkg::PIN_START] = 1'b0;
        end else if (mode_i == far_pkg::MODE_COMM && k < 2) begin
            comm_start_o = (k == 0);
            comm_stop_o  = (k == 1);
            @(negedge ref_clk_i);
            comm_start_o = 1'b0;
            comm_stop_o  = 1'b0;
        end else begin
            pins_o[k] = 1'b1;
            // Four cycles so the two-flop synchroniser sees the press
            repeat (4) @(negedge ref_clk_i);
            // Two-wire start is maintained, the rest are momentary
            if (k != 0 || mode_i != far_pkg::MODE_2W) pins_o[k] = 1'b0;
        end
    endtask : cmd
endmodule : far_cmd_model
`default_nettype wire

// ===== testbench/far_seq_assertions.sv
// Concurrent checks on the auto restart sequencer ports, bound below.
// Assumes clk_en_i is dropped only while no restart pulse stands.
`timescale 1ns/1ps
`default_nettype none
module far_seq_assertions (
    input wire logic                       ref_clk_i,     // Clock
    input wire logic                       rst_n_i,       // Reset, low
    input wire logic                       ar_enable_i,   // Auto restart on
    input wire logic [1:0]                 mode_i,        // Command source
    input wire logic                       hand_opt_i,    // Hand option
    input wire logic                       hand_sel_i,    // Hand selected
    input wire logic [far_pkg::PIN_W-1:0]  pins_i,        // Pins
    input wire logic                       trip_clear_o,  // Clear pulse
    input wire logic                       start_req_o,   // Restart pulse
    input wire logic                       trip_reset_o,  // Reset pulse
    input wire logic                       rst_inhibit_o, // Inhibit level
    input wire logic [far_pkg::CNT_W-1:0]  att_left_o,    // Attempts left
    input wire logic [far_pkg::SEC_W-1:0]  delay_left_o,  // Wait left
    input wire logic [far_pkg::SEC_W-1:0]  free_left_o,   // Free left
    input wire logic                       pending_o,     // Pending
    input wire logic                       lockout_o      // Lockout
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Restart pulse pair and a held hand override
    sequence s_restart; start_req_o && trip_clear_o; endsequence
    sequence s_hand; (hand_opt_i && hand_sel_i) [*3]; endsequence
    a_pulse_pair: assert property (start_req_o == trip_clear_o)
        else $error("trip clear and restart not paired");
    a_pulse_once: assert property (s_restart |=> !start_req_o)
        else $error("restart pulse longer than one cycle");
    a_attempt_used: assert property (s_restart |-> att_left_o == $past(att_left_o) - 4'h1)
        else $error("restart did not use exactly one attempt");
    a_locked_quiet: assert property (lockout_o |-> !start_req_o)
        else $error("restart while locked out");
    a_inhibit_follows: assert property (1'b1 |=> rst_inhibit_o == $past(ar_enable_i))
        else $error("inhibit does not follow enable");
    a_status_range: assert property (att_left_o <= far_pkg::ATT_MAX && delay_left_o <= far_pkg::DELAY_MAX
        && free_left_o <= far_pkg::FREE_MAX) else $error("status out of range");
    a_hand_ends: assert property (s_hand |-> !pending_o && !start_req_o)
        else $error("sequence alive under hand");
    a_two_wire_edge: assert property (mode_i == far_pkg::MODE_2W && $rose(pins_i[far_pkg::PIN_START])
        |-> ##[2:5] trip_reset_o) else $error("no trip reset on start edge");
endmodule : far_seq_assertions
bind far_sequencer far_seq_assertions u_far_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ar_enable_i(ar_enable_i), .mode_i(mode_i),
    .hand_opt_i(hand_opt_i), .hand_sel_i(hand_sel_i), .pins_i(pins_i), .trip_clear_o(trip_clear_o),
    .start_req_o(start_req_o), .trip_reset_o(trip_reset_o), .rst_inhibit_o(rst_inhibit_o),
    .att_left_o(att_left_o), .delay_left_o(delay_left_o), .free_left_o(free_left_o),
    .pending_o(pending_o), .lockout_o(lockout_o)
);
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the auto restart sequencer.
// Assumes the command model drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TK = 8; // Short second keeps trip-free runs brief
    logic                       clk = 1'b0, rst_n = 1'b0, ena = 1'b0, rest = 1'b0, rsa = 1'b0;
    logic                       hopt = 1'b0, hsel = 1'b0, cen = 1'b1, rsph = 1'b0;
    logic [1:0]                 mode = 2'h0;
    logic [far_pkg::SEC_W-1:0]  dly_s = '0, fre_s = '0, rsd = '0, rsfr = '0, dly, fre;
    logic [far_pkg::CNT_W-1:0]  att_s = 4'h2, rsat = '0, att;
    logic [far_pkg::TRIP_W-1:0] trip = '0, tsel = 8'hFF;
    logic [far_pkg::OUT_W-1:0]  outg = '0;
    logic [far_pkg::PIN_W-1:0]  pins;
    logic                       cst, csp, tclr, sreq, pend, lock, trst, rinh, nva, nvp, nvs;
    logic [16:0]                exp_q[$];
    int                         fail_count = 0, tests_run = 0;
    far_sequencer #(.TICK_CYCLES(TK)) u_dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(cen), .ar_enable_i(ena), .delay_s_i(dly_s),
        .attempts_i(att_s), .free_s_i(fre_s), .trip_sel_i(tsel), .trip_i(trip), .mode_i(mode),
        .hand_opt_i(hopt), .hand_sel_i(hsel), .pins_i(pins), .comm_start_i(cst), .comm_stop_i(csp),
        .restore_i(rest), .outage_s_i(outg), .rs_active_i(rsa), .rs_phase_i(rsph),
        .rs_start_i(1'b1), .rs_att_i(rsat), .rs_delay_i(rsd), .rs_free_i(rsfr), .trip_clear_o(tclr),
        .start_req_o(sreq), .trip_reset_o(trst), .rst_inhibit_o(rinh), .att_left_o(att), .delay_left_o(dly),
        .pending_o(pend), .free_left_o(fre), .lockout_o(lock), .nv_active_o(nva), .nv_phase_o(nvp), .nv_start_o(nvs));
    far_cmd_model u_cmd (.ref_clk_i(clk), .mode_i(mode), .pins_o(pins), .comm_start_o(cst), .comm_stop_o(csp));
    // 250 MHz clock
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_hi(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(negedge clk);
    endtask : wait_hi
    // Power cycle: reset for 8 cycles, then one restore pulse
    task automatic power_up(input logic act, input logic [far_pkg::OUT_W-1:0] o);
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        {rsa, outg, rest} = {act, o, 1'b1};
        @(negedge clk);
        rest = 1'b0;
    endtask : power_up
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // Each restart pulse retires the oldest expected status
    always @(negedge clk) begin
        if (sreq === 1'b1) chk({att, fre}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
    initial begin
        int d, f, n;
        d = $urandom(91677);
        power_up(1'b0, '0);
        repeat (4) @(negedge clk);
        ena = 1'b1;
        // Held trip retries until lockout, once per command source
        for (int m = 0; m < 3; m++) begin
            {mode, dly_s, f} = {2'(m), 13'(1 + $urandom % 3), 32'($urandom % 200)};
            fre_s = 13'(f);
            f = (f < 120) ? 120 : f;
            u_cmd.cmd(0);
            repeat (8) @(negedge clk);
            exp_q.push_back({4'h1, 13'(f)});
            exp_q.push_back({4'h0, 13'(f)});
            trip = 8'h01 << m;
            wait_hi(lock, 400);
            trip = '0;
            chk(17'({lock, att}), 17'h00010);
            u_cmd.cmd(2);
            repeat (4) @(negedge clk);
            chk(17'({lock, att}), 17'h00002);
            u_cmd.cmd(3);
            $display("Test lockout, source %0d done", m);
        end
        // A trip outside the resettable set must not start a retry
        {tsel, trip} = {8'h7F, 8'h80};
        repeat (20) @(negedge clk);
        chk(17'({pend, lock}), 17'h00000);
        {tsel, trip} = {8'hFF, 8'h00};
        $display("Test trip mask done");
        // One good restart, counters reload after the trip-free run
        {mode, dly_s, att_s, fre_s} = {far_pkg::MODE_2W, 13'h0000, 4'h1, 13'h0078};
        u_cmd.cmd(0);
        repeat (8) @(negedge clk);
        exp_q.push_back({4'h0, 13'h0078});
        trip = 8'h04;
        wait_hi(sreq, 50);
        trip = '0;
        for (n = 0; n < 1200 && att !== 4'h1; n++) @(negedge clk);
        chk(17'(n >= 119 * TK && n <= 121 * TK), 17'h00001);
        u_cmd.cmd(3);
        $display("Test trip-free reload done");
        // Hand, stop and start removal each end a pending retry
        {dly_s, att_s, hopt} = {13'h0014, 4'h3, 1'b1};
        for (int k = 0; k < 3; k++) begin
            mode = (k == 2) ? far_pkg::MODE_2W : far_pkg::MODE_3W;
            u_cmd.cmd(0);
            repeat (8) @(negedge clk);
            trip = 8'h02;
            wait_hi(pend, 20);
            trip = '0;
            if (k == 0) hsel = 1'b1;
            else u_cmd.cmd(k == 1 ? 1 : 3);
            repeat (6) @(negedge clk);
            hsel = 1'b0;
            chk(17'({pend, att}), 17'h00003);
            repeat (200) @(negedge clk);
            u_cmd.cmd(3);
            $display("Test abort %0d done", k);
        end
        // Power returns: short outage resumes with no start pin, long one ends
        {mode, dly_s, rsat, rsd} = {far_pkg::MODE_3W, 13'h000A, 4'h2, 13'h0009};
        for (int k = 0; k < 2; k++) begin
            d = k ? 31 : 1 + $urandom % 5;
            if (k == 0) exp_q.push_back({4'h1, 13'h0078});
            power_up(1'b1, 24'(d));
            repeat (3) @(negedge clk);
            chk(17'({pend, dly}), k ? 17'h00000 : 17'({1'b1, 13'(9 - d)}));
            // Clock enable low across two tick periods must freeze the wait
            if (k == 0) begin
                cen = 1'b0;
                repeat (20) @(negedge clk);
                cen = 1'b1;
                chk(17'(dly), 17'(9 - d));
            end
            repeat (120) @(negedge clk);
            $display("Test restore %0d done", k);
        end
        // Power returns in the run phase: trip-free time resumes, no retry
        {rsph, rsfr} = {far_pkg::PH_RUN, 13'h0050};
        power_up(1'b1, 24'h000007);
        repeat (3) @(negedge clk);
        chk(17'({rinh, nva, nvp, nvs, pend}), 17'h0001E);
        chk(17'(fre), 17'h00049);
        $display("Test restore run phase done");
        chk(17'(exp_q.size()), 17'h00000);
        finish_test();
    end
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
